// file: shared/aocfg_pkg.sv
`default_nettype none
package aocfg_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_GENERAL = 8'h01;
    localparam logic [7:0] ADDR_FORMAT = 8'h02;
    localparam logic [7:0] ADDR_AVERAGE = 8'h03;
    localparam logic [7:0] ADDR_OPMODE = 8'h04;
    localparam logic [7:0] ADDR_CHANFN = 8'h05;
    // ----------------------------------------
    // Field positions, masks and resets
    // ----------------------------------------
    localparam int CRC_FLAG_BIT = 1;
    localparam int FIXED_PAT_BIT = 7;
    localparam int TAG_SEL_LSB = 4;
    localparam int HALT_BIT = 7;
    localparam int TRIG_LSB = 5;
    localparam int OSC_BIT = 4;
    localparam int DIV_LSB = 0;
    localparam int DIV_WIDTH = 4;
    localparam int AVG_LSB = 0;
    localparam int AVG_WIDTH = 3;
    localparam logic [7:0] FORMAT_MASK = 8'hb0;
    localparam logic [7:0] AVERAGE_MASK = 8'h07;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [11:0] FIXED_CODE = 12'ha5a;
    localparam logic [1:0] TAG_NONE = 2'h0;
    localparam logic [1:0] TAG_CHAN = 2'h1;
    localparam logic [1:0] TAG_STATUS = 2'h2;
    localparam logic [1:0] TAG_RESERVED = 2'h3;
    localparam logic [1:0] TRIG_AUTO_CODE = 2'h1;
    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic {AOCFG_MANUAL, AOCFG_AUTO} aocfg_trig_t;
    typedef struct packed {
        logic valid;
        logic [11:0] code;
        logic tag_valid;
        logic [3:0] tag;
    } aocfg_data_t;
    typedef struct packed {
        aocfg_trig_t trig;
        logic osc_low_power;
        logic [3:0] rate_div;
        logic [7:0] avg_count;
    } aocfg_mode_t;
endpackage : aocfg_pkg
`default_nettype wire

// file: src/aocfg_top.sv
`timescale 1ns/1ns
`default_nettype none
module aocfg_top
    import aocfg_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic crc_error,
    input wire logic conv_valid,
    input wire logic [11:0] conv_result,
    input wire logic [3:0] conv_channel,
    input wire logic [3:0] conv_status,
    output aocfg_data_t out_data,
    output aocfg_mode_t out_mode,
    output logic [CHANNELS-1:0] channel_gpio,
    output logic sequencing_run
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] pow2(input logic [2:0] n);
        pow2 = 8'h01 << n;
    endfunction : pow2

    function automatic logic [1:0] legal2(input logic [1:0] c, input logic [1:0] top);
        legal2 = (c > top) ? 2'h0 : c;
    endfunction : legal2

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic crc_flag_reg;
    logic crc_flag_next;
    logic [7:0] format_reg;
    logic [7:0] average_reg;
    logic [7:0] opmode_reg;
    logic [CHANNELS-1:0] chanfn_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    aocfg_data_t data_reg;
    aocfg_data_t data_next;
    aocfg_mode_t mode_reg;
    aocfg_mode_t mode_next;
    logic [CHANNELS-1:0] gpio_reg;
    logic [CHANNELS-1:0] gpio_next;
    logic run_reg;
    logic run_next;

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    wire logic cfg_open = !crc_flag_reg;
    wire logic wr_status = reg_wr && (reg_addr == ADDR_STATUS);
    wire logic wr_format = reg_wr && cfg_open && (reg_addr == ADDR_FORMAT);
    wire logic wr_average = reg_wr && cfg_open && (reg_addr == ADDR_AVERAGE);
    wire logic wr_opmode = reg_wr && cfg_open && (reg_addr == ADDR_OPMODE);
    wire logic wr_chanfn = reg_wr && cfg_open && (reg_addr == ADDR_CHANFN);
    wire logic flag_clear = wr_status && reg_wdata[CRC_FLAG_BIT];
    // Set wins over clear
    assign crc_flag_next = crc_error || (crc_flag_reg && !flag_clear);

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    wire logic fixed_on = format_reg[FIXED_PAT_BIT];
    wire logic [1:0] tag_sel = legal2(format_reg[TAG_SEL_LSB +: 2], TAG_STATUS);
    wire logic halt_on = opmode_reg[HALT_BIT];
    wire logic [1:0] trig_code = legal2(opmode_reg[TRIG_LSB +: 2], TRIG_AUTO_CODE);
    wire logic trig_auto = (trig_code == TRIG_AUTO_CODE);
    wire logic halted = halt_on && crc_flag_reg;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_STATUS: rdata_next[CRC_FLAG_BIT] = crc_flag_reg;
                ADDR_FORMAT: rdata_next = format_reg & FORMAT_MASK;
                ADDR_AVERAGE: rdata_next = average_reg & AVERAGE_MASK;
                ADDR_OPMODE: rdata_next = opmode_reg;
                ADDR_CHANFN: rdata_next = 8'(chanfn_reg);
                default: rdata_next = 8'h00;
            endcase
        end else begin
            rdata_next = rdata_reg;
        end
    end

    // ----------------------------------------
    // Output data path
    // ----------------------------------------
    always_comb begin
        data_next = '0;
        data_next.valid = conv_valid;
        data_next.code = fixed_on ? FIXED_CODE : conv_result;
        case (tag_sel)
            TAG_CHAN: begin
                data_next.tag_valid = 1'b1;
                data_next.tag = conv_channel;
            end
            TAG_STATUS: begin
                data_next.tag_valid = 1'b1;
                data_next.tag = conv_status;
            end
            default: data_next.tag_valid = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Mode and channel control
    // ----------------------------------------
    always_comb begin
        mode_next.trig = trig_auto ? AOCFG_AUTO : AOCFG_MANUAL;
        mode_next.osc_low_power = opmode_reg[OSC_BIT];
        mode_next.rate_div = trig_auto ? opmode_reg[DIV_LSB +: DIV_WIDTH] : 4'h0;
        mode_next.avg_count = pow2(average_reg[AVG_LSB +: AVG_WIDTH]);
    end
    // Forced analog while halted, restored after clear
    assign gpio_next = halted ? '0 : chanfn_reg;
    assign run_next = !halted;

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            crc_flag_reg <= 1'b0;
            format_reg <= CFG_RESET;
            average_reg <= CFG_RESET;
            opmode_reg <= CFG_RESET;
            chanfn_reg <= '0;
        end else begin
            crc_flag_reg <= crc_flag_next;
            if (wr_format) format_reg <= reg_wdata & FORMAT_MASK;
            if (wr_average) average_reg <= reg_wdata & AVERAGE_MASK;
            if (wr_opmode) opmode_reg <= reg_wdata;
            if (wr_chanfn) chanfn_reg <= reg_wdata[CHANNELS-1:0];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
            data_reg <= '0;
            mode_reg <= '0;
            gpio_reg <= '0;
            run_reg <= 1'b1;
        end else begin
            rdata_reg <= rdata_next;
            data_reg <= data_next;
            mode_reg <= mode_next;
            gpio_reg <= gpio_next;
            run_reg <= run_next;
        end
    end

    assign reg_rdata = rdata_reg;
    assign out_data = data_reg;
    assign out_mode = mode_reg;
    assign channel_gpio = gpio_reg;
    assign sequencing_run = run_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_fixed;
        @(posedge clock) disable iff (!reset_n)
        conv_valid && fixed_on |=> out_data.valid && out_data.code == FIXED_CODE;
    endproperty
    a_fixed: assert property (p_fixed) else $error("fixed code missing");

    property p_tag_chan;
        @(posedge clock) disable iff (!reset_n)
        conv_valid && format_reg[TAG_SEL_LSB +: 2] == TAG_CHAN
            |=> out_data.tag_valid && out_data.tag == $past(conv_channel);
    endproperty
    a_tag_chan: assert property (p_tag_chan) else $error("channel tag wrong");

    property p_tag_rsv;
        @(posedge clock) disable iff (!reset_n)
        format_reg[TAG_SEL_LSB +: 2] == TAG_RESERVED |=> !out_data.tag_valid;
    endproperty
    a_tag_rsv: assert property (p_tag_rsv) else $error("reserved tag used");

    property p_avg;
        @(posedge clock) disable iff (!reset_n)
        wr_average ##2 1
            |-> out_mode.avg_count == pow2($past(reg_wdata[AVG_LSB +: AVG_WIDTH], 2));
    endproperty
    a_avg: assert property (p_avg) else $error("average count wrong");

    property p_keep;
        @(posedge clock) disable iff (!reset_n)
        crc_flag_reg && !halt_on |=> sequencing_run && channel_gpio == $past(chanfn_reg);
    endproperty
    a_keep: assert property (p_keep) else $error("config not kept");

    property p_halt;
        @(posedge clock) disable iff (!reset_n)
        crc_error && halt_on && !wr_opmode ##1 crc_flag_reg
            |=> channel_gpio == '0 && !sequencing_run;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not applied");

    property p_resume;
        @(posedge clock) disable iff (!reset_n)
        $fell(crc_flag_reg) |=> sequencing_run && channel_gpio == $past(chanfn_reg);
    endproperty
    a_resume: assert property (p_resume) else $error("resume failed");

    property p_block;
        @(posedge clock) disable iff (!reset_n)
        crc_flag_reg && reg_wr && reg_addr != ADDR_STATUS && reg_addr != ADDR_GENERAL
            |=> $stable(format_reg) && $stable(average_reg)
                && $stable(opmode_reg) && $stable(chanfn_reg);
    endproperty
    a_block: assert property (p_block) else $error("write not blocked");

    property p_flag_set;
        @(posedge clock) disable iff (!reset_n)
        crc_error |=> crc_flag_reg;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set");

    property p_mode;
        @(posedge clock) disable iff (!reset_n)
        opmode_reg[TRIG_LSB +: 2] == TRIG_AUTO_CODE
            |=> out_mode.trig == AOCFG_AUTO
                && out_mode.rate_div == $past(opmode_reg[DIV_LSB +: DIV_WIDTH])
                && out_mode.osc_low_power == $past(opmode_reg[OSC_BIT]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode output wrong");

    property p_rsv_read;
        @(posedge clock) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_FORMAT |=> (reg_rdata & ~FORMAT_MASK) == 8'h00;
    endproperty
    a_rsv_read: assert property (p_rsv_read) else $error("reserved bits set");

    property p_plain_code;
        @(posedge clock) disable iff (!reset_n)
        conv_valid && !fixed_on |=> out_data.valid && out_data.code == $past(conv_result);
    endproperty
    a_plain_code: assert property (p_plain_code) else $error("result code wrong");

    property p_tag_status;
        @(posedge clock) disable iff (!reset_n)
        conv_valid && format_reg[TAG_SEL_LSB +: 2] == TAG_STATUS
            |=> out_data.tag_valid && out_data.tag == $past(conv_status);
    endproperty
    a_tag_status: assert property (p_tag_status) else $error("status tag wrong");

    property p_tag_none;
        @(posedge clock) disable iff (!reset_n)
        format_reg[TAG_SEL_LSB +: 2] == TAG_NONE |=> !out_data.tag_valid;
    endproperty
    a_tag_none: assert property (p_tag_none) else $error("tag added when off");

    property p_manual;
        @(posedge clock) disable iff (!reset_n)
        opmode_reg[TRIG_LSB +: 2] != TRIG_AUTO_CODE
            |=> out_mode.trig == AOCFG_MANUAL && out_mode.rate_div == 4'h0;
    endproperty
    a_manual: assert property (p_manual) else $error("manual mode wrong");

    property p_avg_read;
        @(posedge clock) disable iff (!reset_n)
        reg_rd && reg_addr == ADDR_AVERAGE |=> (reg_rdata & ~AVERAGE_MASK) == 8'h00;
    endproperty
    a_avg_read: assert property (p_avg_read) else $error("reserved average bits set");

    property p_clear;
        @(posedge clock) disable iff (!reset_n)
        crc_flag_reg && flag_clear && !crc_error |=> !crc_flag_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared");

    property p_pin_fn;
        @(posedge clock) disable iff (!reset_n)
        !halted |=> channel_gpio == $past(chanfn_reg);
    endproperty
    a_pin_fn: assert property (p_pin_fn) else $error("pin function wrong");
endmodule : aocfg_top
`default_nettype wire

// file: sim/aocfg_host.sv
`timescale 1ns/1ns
`default_nettype none
module aocfg_host
    import aocfg_pkg::*;
(
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // ----------------------------------------
    // One register transfer, host starts it
    // ----------------------------------------
    task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : xfer
    // Flag clear by writing one
    task automatic clear_crc();
        xfer(ADDR_STATUS, 8'h02, 1'b1);
    endtask : clear_crc
endmodule : aocfg_host
`default_nettype wire

// file: sim/aocfg_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module aocfg_top_bench
    import aocfg_pkg::*;
;
    logic clock = 1'b0;
    logic reset_n, reg_wr, reg_rd, crc_error, conv_valid, rd_hit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, channel_gpio, g, v;
    logic [11:0] conv_result;
    logic [3:0] conv_channel, conv_status;
    logic sequencing_run;
    aocfg_data_t out_data, e, ex;
    aocfg_mode_t out_mode;
    logic [7:0] rq[$];
    aocfg_data_t dq[$];
    int error_cnt = 0;
    int comparisons = 0;
    int seed = 21;
    always #5 clock = ~clock;
    aocfg_top i_dut (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .crc_error(crc_error), .conv_valid(conv_valid), .conv_result(conv_result),
        .conv_channel(conv_channel), .conv_status(conv_status), .out_data(out_data),
        .out_mode(out_mode), .channel_gpio(channel_gpio), .sequencing_run(sequencing_run));
    aocfg_host i_host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : check
    task automatic conclude();
        $display("comparisons=%0d errors=%0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        rq.push_back(x);
        i_host.xfer(a, 8'h00, 1'b0);
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask : settle
    task automatic conv(input logic [11:0] r, input logic [3:0] c, input logic [3:0] s);
        dq.push_back(e);
        @(posedge clock);
        #1;
        conv_valid = 1'b1;
        conv_result = r;
        conv_channel = c;
        conv_status = s;
        @(posedge clock);
        #1;
        conv_valid = 1'b0;
        conv_result = ~r;
    endtask : conv
    // ----------------------------------------
    // Monitor: oldest note against each result
    // ----------------------------------------
    always @(posedge clock) rd_hit <= reg_rd;
    always @(negedge clock) begin
        if (rd_hit === 1'b1) check(reg_rdata, rq.pop_front());
        if (out_data.valid === 1'b1) begin
            ex = dq.pop_front();
            check({out_data.code, out_data.tag_valid}, {ex.code, ex.tag_valid});
            if (ex.tag_valid) check(out_data.tag, ex.tag);
        end
    end
    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        reset_n = 1'b0;
        crc_error = 1'b0;
        conv_valid = 1'b0;
        conv_result = 12'h000;
        conv_channel = 4'h0;
        conv_status = 4'h0;
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        @(posedge clock);
        #1;
        check(out_mode.avg_count, 8'h01);
        for (int a = 2; a < 6; a++) rd(a[7:0], CFG_RESET);
        rd(8'h0c, 8'h00);
        for (int i = 0; i < 16; i++) begin
            v = {i[2], 1'b0, i[1:0], 4'h0} | (8'($random(seed)) & ~FORMAT_MASK);
            i_host.xfer(ADDR_FORMAT, v, 1'b1);
            rd(ADDR_FORMAT, v & FORMAT_MASK);
            g = 8'($random(seed));
            e.valid = 1'b1;
            e.code = i[2] ? FIXED_CODE : {g, i[3:0]};
            e.tag_valid = (i[1:0] == TAG_CHAN) || (i[1:0] == TAG_STATUS);
            e.tag = (i[1:0] == TAG_CHAN) ? g[3:0] : g[7:4];
            conv({g, i[3:0]}, g[3:0], g[7:4]);
        end
        for (int n = 0; n < 8; n++) begin
            v = {5'($random(seed)), n[2:0]};
            i_host.xfer(ADDR_AVERAGE, v, 1'b1);
            rd(ADDR_AVERAGE, v & AVERAGE_MASK);
            settle();
            check(out_mode.avg_count, 8'h01 << n);
        end
        for (int i = 0; i < 8; i++) begin
            g = 8'($random(seed));
            v = {1'b0, i[1:0], i[2], g[3:0]};
            i_host.xfer(ADDR_OPMODE, v, 1'b1);
            rd(ADDR_OPMODE, v);
            settle();
            check(out_mode.trig, i[1:0] == TRIG_AUTO_CODE);
            check(out_mode.osc_low_power, i[2]);
            check(out_mode.rate_div, (i[1:0] == TRIG_AUTO_CODE) ? g[3:0] : 4'h0);
        end
        for (int h = 0; h < 2; h++) begin
            g = 8'($random(seed));
            i_host.xfer(ADDR_OPMODE, {h[0], 7'h20}, 1'b1);
            i_host.xfer(ADDR_CHANFN, g, 1'b1);
            settle();
            check(channel_gpio, g);
            @(posedge clock);
            #1;
            crc_error = 1'b1;
            @(posedge clock);
            #1;
            crc_error = 1'b0;
            settle();
            check(channel_gpio, h ? 8'h00 : g);
            check(sequencing_run, !h[0]);
            rd(ADDR_STATUS, 8'h02);
            i_host.xfer(ADDR_CHANFN, ~g, 1'b1);
            rd(ADDR_CHANFN, g);
            i_host.xfer(ADDR_OPMODE, 8'h00, 1'b1);
            rd(ADDR_OPMODE, {h[0], 7'h20});
            i_host.clear_crc();
            settle();
            check(channel_gpio, g);
            check(sequencing_run, 1'b1);
            rd(ADDR_STATUS, 8'h00);
        end
        settle();
        check(rq.size() + dq.size(), 0);
        conclude();
    end
endmodule : aocfg_top_bench
`default_nettype wire
